// ### hw/eimp_pkg.sv
// package for the extended interrupt mask and priority block
// assumes an 8-bit special-function register bus driven by the cpu core
package eimp_pkg;
    // special-function register addresses
    localparam logic [7:0] EIMP_ADDR_EN_ONE   = 8'he6;
    localparam logic [7:0] EIMP_ADDR_EN_TWO   = 8'he7;
    localparam logic [7:0] EIMP_ADDR_PRIO_ONE = 8'hf6;

    // reset values
    localparam logic [7:0] EIMP_RST_EN_ONE    = 8'h00;
    localparam logic [7:0] EIMP_RST_EN_TWO    = 8'h00;
    localparam logic [7:0] EIMP_RST_PRIO_ONE  = 8'h00;
    localparam logic [7:0] EIMP_RD_UNMAPPED   = 8'h00;

    // register one bit positions (also source index 0..7)
    localparam int EIMP_B1_SPI          = 0;
    localparam int EIMP_B1_SMBUS        = 1;
    localparam int EIMP_B1_CONV_WINDOW  = 2;
    localparam int EIMP_B1_COUNTER_ARR  = 3;
    localparam int EIMP_B1_CMP_ZERO_F   = 4;
    localparam int EIMP_B1_CMP_ZERO_R   = 5;
    localparam int EIMP_B1_CMP_ONE_F    = 6;
    localparam int EIMP_B1_CMP_ONE_R    = 7;

    // register two bit positions (source index 8..15 minus 8)
    localparam int EIMP_B2_TIMER_THREE  = 0;
    localparam int EIMP_B2_MAIN_EOC     = 1;
    localparam int EIMP_B2_TIMER_FOUR   = 2;
    localparam int EIMP_B2_SLOW_EOC     = 3;
    localparam int EIMP_B2_EXT_SIX      = 4;
    localparam int EIMP_B2_EXT_SEVEN    = 5;
    localparam int EIMP_B2_SECOND_UART  = 6;
    localparam int EIMP_B2_OSC_VALID    = 7;

    // sizes
    localparam int EIMP_REG_W     = 8;
    localparam int EIMP_NUM_SRC   = 16;
    localparam int EIMP_NUM_PRIO  = 8;
    localparam logic EIMP_PRIO_LOW  = 1'b0;
    localparam logic EIMP_PRIO_HIGH = 1'b1;
endpackage

// ### hw/eimp_gate_if.sv
// interface between the register file and the gating cell
// assumes one clock domain; signals are plain levels
`timescale 1ns/10ps
interface eimp_gate_if #(
    parameter int NUM_SRC  = 16,
    parameter int NUM_PRIO = 8
);
    logic [NUM_SRC-1:0]  flags;
    logic [NUM_SRC-1:0]  enables;
    logic [NUM_PRIO-1:0] prio_bits;
    logic                global_en;
    logic [NUM_SRC-1:0]  req;
    logic [NUM_PRIO-1:0] high;

    modport ctrl (output flags, output enables, output prio_bits, output global_en,
                  input req, input high);
    modport gate (input flags, input enables, input prio_bits, input global_en,
                  output req, output high);
endinterface // eimp_gate_if

// ### hw/eimp_gate.sv
// combinational gating of source flags by enables, global enable and priority
// assumes the caller registers the results before they leave the block
`timescale 1ns/10ps
module eimp_gate #(
    parameter int NUM_SRC  = 16,
    parameter int NUM_PRIO = 8
) (
    // gating signals
    eimp_gate_if.gate gif
);
    import eimp_pkg::*;

    // flag is never cleared here, so a pending flag shows once enabled
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            gif.req[i] = gif.flags[i] & gif.enables[i] & gif.global_en;
        end
    end

    // high level only for a request that is actually forwarded
    always_comb begin
        for (int j = 0; j < NUM_PRIO; j++) begin
            gif.high[j] = gif.req[j] & (gif.prio_bits[j] == EIMP_PRIO_HIGH);
        end
    end
endmodule // eimp_gate

// ### hw/eimp_top.sv
// extended interrupt mask and priority registers with request gating
// assumes the cpu core drives the sfr bus synchronously and holds the global enable bit
// requests are registered, so they trail their flags and enables by one clock
`timescale 1ns/10ps
module eimp_top #(
    parameter int NUM_SRC  = eimp_pkg::EIMP_NUM_SRC,
    parameter int NUM_PRIO = eimp_pkg::EIMP_NUM_PRIO
) (
    // clock and reset
    input  wire logic                           i_ref_clk,
    input  wire logic                           i_reset,
    // sfr bus from the core
    input  wire logic [7:0]                     i_sfr_addr,
    input  wire logic                           i_sfr_wr,
    input  wire logic                           i_sfr_rd,
    input  wire logic [eimp_pkg::EIMP_REG_W-1:0] i_sfr_wdata,
    output logic      [eimp_pkg::EIMP_REG_W-1:0] o_sfr_rdata,
    output logic                                o_sfr_hit,
    // global enable from the core's own enable register
    input  wire logic                           i_global_irq_en,
    // source flags, levels held by the peripherals
    input  wire logic                           i_spi_done_flag,
    input  wire logic                           i_smbus_flag,
    input  wire logic                           i_converter_window_flag,
    input  wire logic                           i_counter_array_flag,
    input  wire logic                           i_cmp_zero_fall_flag,
    input  wire logic                           i_cmp_zero_rise_flag,
    input  wire logic                           i_cmp_one_fall_flag,
    input  wire logic                           i_cmp_one_rise_flag,
    input  wire logic                           i_timer_three_overflow,
    input  wire logic                           i_main_converter_eoc_flag,
    input  wire logic                           i_timer_four_overflow,
    input  wire logic                           i_slow_converter_eoc_flag,
    input  wire logic                           i_ext_pin_six_flag,
    input  wire logic                           i_ext_pin_seven_flag,
    input  wire logic                           i_second_uart_flag,
    input  wire logic                           i_osc_valid_flag,
    // gated requests to the interrupt sequencer
    output logic      [NUM_SRC-1:0]             o_irq_req,
    output logic      [NUM_PRIO-1:0]            o_irq_high_prio
);
    import eimp_pkg::*;

    logic [EIMP_REG_W-1:0] en_one_ff;
    logic [EIMP_REG_W-1:0] en_two_ff;
    logic [EIMP_REG_W-1:0] prio_one_ff;
    logic [EIMP_REG_W-1:0] nxt_rdata;
    logic                  nxt_hit;
    logic [7:0]            flags_one;
    logic [7:0]            flags_two;
    logic                  wr_en_one;
    logic                  wr_en_two;
    logic                  wr_prio_one;
    logic [EIMP_REG_W-1:0] nxt_en_one;
    logic [EIMP_REG_W-1:0] nxt_en_two;
    logic [EIMP_REG_W-1:0] nxt_prio_one;
    logic [NUM_SRC-1:0]    nxt_irq_req;
    logic [NUM_PRIO-1:0]   nxt_irq_high;

    eimp_gate_if #(.NUM_SRC(NUM_SRC), .NUM_PRIO(NUM_PRIO)) gif ();

    // write strobes, one per register; other addresses fall through untouched
    assign wr_en_one   = i_sfr_wr && (i_sfr_addr == EIMP_ADDR_EN_ONE);
    assign wr_en_two   = i_sfr_wr && (i_sfr_addr == EIMP_ADDR_EN_TWO);
    assign wr_prio_one = i_sfr_wr && (i_sfr_addr == EIMP_ADDR_PRIO_ONE);

    // next value of enable register one; holds unless its strobe is up
    always_comb begin
        nxt_en_one = en_one_ff;
        if (wr_en_one) begin
            nxt_en_one = i_sfr_wdata;
        end
    end

    // next value of enable register two
    always_comb begin
        nxt_en_two = en_two_ff;
        if (wr_en_two) begin
            nxt_en_two = i_sfr_wdata;
        end
    end

    // next value of priority register one
    always_comb begin
        nxt_prio_one = prio_one_ff;
        if (wr_prio_one) begin
            nxt_prio_one = i_sfr_wdata;
        end
    end

    // enable register one; low bits gate counter array, window, smbus, spi
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            en_one_ff <= EIMP_RST_EN_ONE;
        end else begin
            en_one_ff <= nxt_en_one;
        end
    end

    // enable register two, all sources masked out of reset
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            en_two_ff <= EIMP_RST_EN_TWO;
        end else begin
            en_two_ff <= nxt_en_two;
        end
    end

    // priority register one
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            prio_one_ff <= EIMP_RST_PRIO_ONE;
        end else begin
            prio_one_ff <= nxt_prio_one;
        end
    end

    // read decode; unmapped addresses read zero and do not claim the bus
    always_comb begin
        nxt_rdata = EIMP_RD_UNMAPPED;
        nxt_hit   = 1'b0;
        if (i_sfr_rd) begin
            unique case (i_sfr_addr)
                EIMP_ADDR_EN_ONE: begin
                    nxt_rdata = en_one_ff;
                    nxt_hit   = 1'b1;
                end
                EIMP_ADDR_EN_TWO: begin
                    nxt_rdata = en_two_ff;
                    nxt_hit   = 1'b1;
                end
                EIMP_ADDR_PRIO_ONE: begin
                    nxt_rdata = prio_one_ff;
                    nxt_hit   = 1'b1;
                end
                default: begin
                    nxt_rdata = EIMP_RD_UNMAPPED;
                    nxt_hit   = 1'b0;
                end
            endcase
        end
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_sfr_rdata <= EIMP_RD_UNMAPPED;
            o_sfr_hit   <= 1'b0;
        end else begin
            o_sfr_rdata <= nxt_rdata;
            o_sfr_hit   <= nxt_hit;
        end
    end

    // pack flags into register-bit order so enables line up bit for bit
    always_comb begin
        flags_one = 8'h00;
        flags_one[EIMP_B1_SPI]         = i_spi_done_flag;
        flags_one[EIMP_B1_SMBUS]       = i_smbus_flag;
        flags_one[EIMP_B1_CONV_WINDOW] = i_converter_window_flag;
        flags_one[EIMP_B1_COUNTER_ARR] = i_counter_array_flag;
        flags_one[EIMP_B1_CMP_ZERO_F]  = i_cmp_zero_fall_flag;
        flags_one[EIMP_B1_CMP_ZERO_R]  = i_cmp_zero_rise_flag;
        flags_one[EIMP_B1_CMP_ONE_F]   = i_cmp_one_fall_flag;
        flags_one[EIMP_B1_CMP_ONE_R]   = i_cmp_one_rise_flag;
    end

    // second group in enable-two bit order
    always_comb begin
        flags_two = 8'h00;
        flags_two[EIMP_B2_TIMER_THREE] = i_timer_three_overflow;
        flags_two[EIMP_B2_MAIN_EOC]    = i_main_converter_eoc_flag;
        flags_two[EIMP_B2_TIMER_FOUR]  = i_timer_four_overflow;
        flags_two[EIMP_B2_SLOW_EOC]    = i_slow_converter_eoc_flag;
        flags_two[EIMP_B2_EXT_SIX]     = i_ext_pin_six_flag;
        flags_two[EIMP_B2_EXT_SEVEN]   = i_ext_pin_seven_flag;
        flags_two[EIMP_B2_SECOND_UART] = i_second_uart_flag;
        flags_two[EIMP_B2_OSC_VALID]   = i_osc_valid_flag;
    end

    // feed the gating cell; each enable bit sits over its own flag
    assign gif.flags     = {flags_two, flags_one};
    assign gif.enables   = {en_two_ff, en_one_ff};
    assign gif.prio_bits = prio_one_ff;
    assign gif.global_en = i_global_irq_en;

    eimp_gate #(
        .NUM_SRC  (NUM_SRC),
        .NUM_PRIO (NUM_PRIO)
    ) u_gate (
        .gif (gif)
    );

    // next request levels, taken straight from the gating cell
    assign nxt_irq_req  = gif.req;
    assign nxt_irq_high = gif.high;

    // registered request outputs; costs one cycle of latency, keeps outputs glitch free
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_irq_req       <= '0;
            o_irq_high_prio <= '0;
        end else begin
            o_irq_req       <= nxt_irq_req;
            o_irq_high_prio <= nxt_irq_high;
        end
    end
endmodule // eimp_top

// ### test/eimp_sva.sv
// port checker for eimp_top
// assumes one clock domain and the bind at the foot
`timescale 1ns/10ps
module eimp_sva
    import eimp_pkg::*;
#(
    parameter int NUM_SRC  = 16,
    parameter int NUM_PRIO = 8
) (
    // watched ports
    input wire logic                i_ref_clk, i_reset, i_sfr_wr, i_sfr_rd,
    input wire logic                i_global_irq_en, i_spi_done_flag,
    input wire logic                i_timer_three_overflow, o_sfr_hit,
    input wire logic [7:0]          i_sfr_addr, i_sfr_wdata, o_sfr_rdata,
    input wire logic [NUM_SRC-1:0]  o_irq_req,
    input wire logic [NUM_PRIO-1:0] o_irq_high_prio
);
    logic mapped;
    // decode kept here so each property stays short
    assign mapped = i_sfr_addr inside {EIMP_ADDR_EN_ONE, EIMP_ADDR_EN_TWO, EIMP_ADDR_PRIO_ONE};
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    property p_glob; !i_global_irq_en |=> o_irq_req == '0; endproperty
    a_glob: assert property (p_glob) else $error("request while global off");
    property p_spi; !i_spi_done_flag |=> !o_irq_req[0]; endproperty
    a_spi: assert property (p_spi) else $error("spi request without flag");
    property p_t3; !i_timer_three_overflow |=> !o_irq_req[8]; endproperty
    a_t3: assert property (p_t3) else $error("timer three without flag");
    property p_hi; (o_irq_high_prio & ~o_irq_req[7:0]) == '0; endproperty
    a_hi: assert property (p_hi) else $error("high level on idle source");
    property p_unm; i_sfr_rd && !mapped |=> o_sfr_rdata == 8'h00 && !o_sfr_hit; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read answered");
    property p_hit; i_sfr_rd && mapped |=> o_sfr_hit; endproperty
    a_hit: assert property (p_hit) else $error("mapped read not answered");
    property p_idle; !i_sfr_rd |=> o_sfr_rdata == 8'h00 && !o_sfr_hit; endproperty
    a_idle: assert property (p_idle) else $error("read answer without strobe");
    property p_wrd;
        i_sfr_wr && i_sfr_addr == EIMP_ADDR_EN_TWO ##1 i_sfr_rd && i_sfr_addr == EIMP_ADDR_EN_TWO
        |=> o_sfr_rdata == $past(i_sfr_wdata, 2);
    endproperty
    a_wrd: assert property (p_wrd) else $error("write not read back");
    property p_rst;
        disable iff (1'b0) i_reset |=> o_irq_req == '0 && o_irq_high_prio == '0 && !o_sfr_hit;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs live in reset");
    c_osc: cover property (o_irq_req[15]);
    c_hit: cover property (o_sfr_hit);
    c_hi: cover property (|o_irq_high_prio);
endmodule // eimp_sva
bind eimp_top eimp_sva #(.NUM_SRC(NUM_SRC), .NUM_PRIO(NUM_PRIO)) eimp_sva_i (.*);

// ### test/eimp_seq_model.sv
// stand-in for the core's interrupt sequencer
// assumes registered request levels from eimp_top
`timescale 1ns/10ps
module eimp_seq_model (
    // requests in, service view out
    input  wire logic        i_ref_clk,
    input  wire logic [15:0] i_req,
    input  wire logic [7:0]  i_high,
    output logic             o_pend,
    output logic             o_top
);
    // note pending work and whether a high level one waits
    always_ff @(posedge i_ref_clk) begin
        o_pend <= |i_req;
        o_top  <= |i_high;
    end
endmodule // eimp_seq_model

// ### test/eimp_top_tb.sv
// self-checking bench for eimp_top
// assumes eimp_sva is bound from its own file
`timescale 1ns/10ps
module eimp_top_tb;
    import eimp_pkg::*;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("Error %0t: got %h want %h", $time, g, e); end end
    logic        clk = 0, rst = 1, wr = 0, rd = 0, glob = 0, hit, rd_seen = 0, pend, top;
    logic [7:0]  addr = 0, wdata = 0, rdata, en1 = 0, en2 = 0, pr = 0, hi;
    logic [15:0] fl = 0, req, m;
    logic [8:0]  rdq[$];
    logic [25:0] iq[$];
    int          err_count = 0, tests_run = 0;
    eimp_top eimp_top_i (.i_ref_clk(clk), .i_reset(rst), .i_sfr_addr(addr), .i_sfr_wr(wr),
        .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .o_sfr_hit(hit),
        .i_global_irq_en(glob), .i_spi_done_flag(fl[0]), .i_smbus_flag(fl[1]),
        .i_converter_window_flag(fl[2]), .i_counter_array_flag(fl[3]),
        .i_cmp_zero_fall_flag(fl[4]), .i_cmp_zero_rise_flag(fl[5]),
        .i_cmp_one_fall_flag(fl[6]), .i_cmp_one_rise_flag(fl[7]),
        .i_timer_three_overflow(fl[8]), .i_main_converter_eoc_flag(fl[9]),
        .i_timer_four_overflow(fl[10]), .i_slow_converter_eoc_flag(fl[11]),
        .i_ext_pin_six_flag(fl[12]), .i_ext_pin_seven_flag(fl[13]),
        .i_second_uart_flag(fl[14]), .i_osc_valid_flag(fl[15]), .o_irq_req(req),
        .o_irq_high_prio(hi));
    eimp_seq_model eimp_seq_model_i (.i_ref_clk(clk), .i_req(req), .i_high(hi),
        .o_pend(pend), .o_top(top));
    initial forever #10 clk = ~clk;
    // oldest note is matched when a result shows, half a cycle after it lands
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) begin
        #1;
        if (rd_seen) `CHK({hit, rdata}, rdq.pop_front())
        if (iq.size() > 0) `CHK({req, hi, pend, top}, iq.pop_front())
    end
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1;
        @(negedge clk);
        wr = 0;
        if (a == EIMP_ADDR_EN_ONE) en1 = d;
        if (a == EIMP_ADDR_EN_TWO) en2 = d;
        if (a == EIMP_ADDR_PRIO_ONE) pr = d;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [8:0] e);
        @(negedge clk);
        addr = a;
        rd = 1;
        rdq.push_back(e);
        @(negedge clk);
        rd = 0;
    endtask
    // expectation from the mirrors, two edges after the last change
    task automatic chk_irq();
        logic [15:0] r;
        repeat (2) @(negedge clk);
        r = glob ? fl & {en2, en1} : 16'h0000;
        iq.push_back({r, r[7:0] & pr, |r, |(r[7:0] & pr)});
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h2fb0b527));
        repeat (2) @(negedge clk);
        rst = 0;
        rd_reg(EIMP_ADDR_EN_ONE, 9'h100);
        rd_reg(EIMP_ADDR_EN_TWO, 9'h100);
        rd_reg(EIMP_ADDR_PRIO_ONE, 9'h100);
        rd_reg(8'he5, 9'h000);
        $display("reset values done");
        // one enable at a time with every flag up
        glob = 1;
        fl = 16'hffff;
        // a write to an unmapped address must leave every mask closed
        wr_reg(8'he5, 8'hff);
        chk_irq();
        for (int i = 0; i < 16; i++) begin
            m = 16'h0001 << i;
            wr_reg(EIMP_ADDR_EN_ONE, m[7:0]);
            wr_reg(EIMP_ADDR_EN_TWO, m[15:8]);
            chk_irq();
        end
        $display("single enables done");
        // flag held while masked must request once enabled
        wr_reg(EIMP_ADDR_EN_TWO, 8'h00);
        fl = 16'h8000;
        chk_irq();
        wr_reg(EIMP_ADDR_EN_TWO, 8'h80);
        chk_irq();
        // write directly followed by a read of the same place
        @(negedge clk);
        addr = EIMP_ADDR_EN_TWO;
        wdata = 8'h5a;
        wr = 1;
        @(negedge clk);
        wr = 0;
        rd = 1;
        en2 = 8'h5a;
        rdq.push_back(9'h15a);
        @(negedge clk);
        rd = 0;
        $display("pending and readback done");
        repeat (24) begin
            wr_reg(EIMP_ADDR_EN_ONE, 8'($urandom));
            wr_reg(EIMP_ADDR_EN_TWO, 8'($urandom));
            wr_reg(EIMP_ADDR_PRIO_ONE, 8'($urandom));
            fl = 16'($urandom);
            glob = 1'($urandom);
            chk_irq();
            rd_reg(EIMP_ADDR_PRIO_ONE, {1'b1, pr});
        end
        $display("random done");
        // mid-run reset must clear every register again
        @(negedge clk);
        rst = 1;
        repeat (2) @(negedge clk);
        rst = 0;
        en1 = 8'h00;
        en2 = 8'h00;
        pr = 8'h00;
        glob = 1;
        fl = 16'hffff;
        chk_irq();
        rd_reg(EIMP_ADDR_EN_ONE, 9'h100);
        rd_reg(EIMP_ADDR_EN_TWO, 9'h100);
        rd_reg(EIMP_ADDR_PRIO_ONE, 9'h100);
        $display("mid-run reset done");
        repeat (3) @(negedge clk);
        tally_and_finish();
    end
endmodule // eimp_top_tb
